//--- hw/exarb_pkg.sv
package exarb_pkg;

  // number of maskable hardware sources, first flag at index 0
  localparam int NSRC = 21;
  localparam int IDX_W = 5;

  // vector selection codes
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_SWI = 16'hfffc;
  localparam logic [15:0] VEC_FIRST = 16'hfffa;

  // register addresses
  localparam logic [15:0] ADDR_BRK_FLAG_CTRL = 16'hfe03;
  localparam logic [15:0] ADDR_PEND_LOW = 16'hfe04;
  localparam logic [15:0] ADDR_PEND_MID = 16'hfe05;
  localparam logic [15:0] ADDR_PEND_HIGH = 16'hfe06;
  localparam logic [15:0] ADDR_EVT_STAT = 16'hfe07;
  localparam logic [15:0] ADDR_EVT_MASK = 16'hfe08;

  // field layout of the pending registers
  localparam int LOW_LSB = 2;
  localparam int LOW_CNT = 6;
  localparam int MID_BASE = 6;
  localparam int MID_CNT = 8;
  localparam int HIGH_BASE = 14;
  localparam int HIGH_CNT = 7;

  // break flag control field
  localparam int BREAK_CLEAR_FLAG_ENABLE_BIT = 7;

  // event status bits
  localparam int EVT_W = 3;
  localparam int EVT_HW = 0;
  localparam int EVT_SWI = 1;
  localparam int EVT_BRK = 2;

  typedef enum logic [0:0] {M_RUN, M_BREAK} exarb_mode_t;

  typedef struct packed {
    exarb_mode_t mode;
    logic in_brk;
    logic [NSRC-1:0] pend;
    logic sel_valid;
    logic [IDX_W-1:0] sel_idx;
    logic imask_q;
    logic take;
    logic take_reset;
    logic [15:0] vector;
    logic pc_dec;
    logic stack_h;
    logic set_imask;
    logic restore;
    logic break_clear_flag_enable;
    logic clr_allow;
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_mask;
    logic irq;
    logic [7:0] rdata;
  } exarb_state_t;

endpackage : exarb_pkg

//--- hw/exarb_exception_arbiter.sv
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module exarb_exception_arbiter
  import exarb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NSRC-1:0] irq_src,
  input wire logic [NSRC-1:0] irq_enable,
  input wire logic i_mask,
  input wire logic instr_done,
  input wire logic swi_exec,
  input wire logic rti_exec,
  input wire logic break_req,
  input wire logic reset_req,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [7:0] rdata,
  output logic int_take,
  output logic reset_take,
  output logic [15:0] vector_addr,
  output logic stack_pc_dec,
  output logic stack_index_high,
  output logic set_int_mask,
  output logic restore_regs,
  output logic in_break,
  output logic flag_clear_allow,
  output logic irq
);

  exarb_state_t s_reg;
  exarb_state_t s_next;
  logic [NSRC-1:0] cand;

  //////////////////////////////////////////////////////////////////////////////
  // lowest index wins, index 0 is the highest priority source
  function automatic logic [IDX_W-1:0] first_set(input logic [NSRC-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction : first_set

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.take = 1'h0;
    s_next.take_reset = 1'h0;
    s_next.set_imask = 1'h0;
    s_next.restore = 1'h0;
    s_next.stack_h = 1'h0; // index-high never pushed by hardware
    s_next.imask_q = i_mask;
    s_next.pend = irq_src; // raw request presence for status
    cand = s_reg.pend & irq_enable; // only enabled sources compete

    // a latched winner is kept; clearing the mask reopens arbitration
    if (s_reg.sel_valid && s_reg.imask_q && !i_mask) begin
      s_next.sel_valid = 1'h0;
    end else if (!s_reg.sel_valid && |cand) begin
      s_next.sel_valid = 1'h1;
      s_next.sel_idx = first_set(cand);
    end

    // reset is outside arbitration and beats every other source
    if (reset_req) begin
      s_next.take_reset = 1'h1;
      s_next.vector = VEC_RESET;
      s_next.sel_valid = 1'h0;
      s_next.mode = M_RUN;
      s_next.in_brk = 1'h0;
    end else if (instr_done) begin // nothing starts mid-instruction
      if (break_req) begin
        s_next.take = 1'h1;
        s_next.set_imask = 1'h1;
        s_next.vector = VEC_SWI; // break rides the software vector
        s_next.pc_dec = 1'h0;
        s_next.mode = M_BREAK;
        s_next.in_brk = 1'h1;
      end else if (swi_exec) begin
        s_next.take = 1'h1; // mask is not consulted here
        s_next.set_imask = 1'h1;
        s_next.vector = VEC_SWI;
        s_next.pc_dec = 1'h0; // stacks PC itself
      end else if (!i_mask && s_reg.sel_valid) begin
        // a request left over at return is taken at this boundary
        s_next.take = 1'h1;
        s_next.set_imask = 1'h1;
        s_next.vector = VEC_FIRST - 16'({s_reg.sel_idx, 1'h0});
        s_next.pc_dec = 1'h1; // hardware entry stacks PC minus one
        s_next.sel_valid = 1'h0;
      end
    end

    // return from interrupt restores the stacked registers and ends break
    if (rti_exec && !reset_req) begin
      s_next.restore = 1'h1;
      s_next.mode = M_RUN;
      s_next.in_brk = 1'h0;
    end

    // register writes; pending registers have no write path
    if (we) begin
      unique case (addr)
        ADDR_BRK_FLAG_CTRL: s_next.break_clear_flag_enable = wdata[BREAK_CLEAR_FLAG_ENABLE_BIT];
        ADDR_EVT_MASK: s_next.evt_mask = wdata[EVT_W-1:0];
        ADDR_EVT_STAT: s_next.evt_stat = s_reg.evt_stat & ~wdata[EVT_W-1:0];
        default: ;
      endcase
    end

    // hardware sets win over a one-to-clear in the same cycle
    s_next.evt_stat[EVT_HW] = s_next.evt_stat[EVT_HW] | (s_next.take & s_next.pc_dec);
    s_next.evt_stat[EVT_SWI] = s_next.evt_stat[EVT_SWI] | (s_next.take & ~s_next.pc_dec & ~s_next.in_brk);
    s_next.evt_stat[EVT_BRK] = s_next.evt_stat[EVT_BRK] | (s_next.take & s_next.in_brk);
    s_next.irq = |(s_next.evt_stat & s_next.evt_mask);

    // a level gate: flags cleared while it is open stay cleared, and a
    // two-step clear started earlier just waits for the gate
    s_next.clr_allow = !s_next.in_brk || s_next.break_clear_flag_enable;

    // read data stands only in the cycle after the strobe; reads change nothing
    s_next.rdata = '0;
    if (re) begin
      unique case (addr)
        ADDR_PEND_LOW: s_next.rdata[LOW_LSB +: LOW_CNT] = s_reg.pend[0 +: LOW_CNT];
        ADDR_PEND_MID: s_next.rdata[0 +: MID_CNT] = s_reg.pend[MID_BASE +: MID_CNT];
        ADDR_PEND_HIGH: s_next.rdata[0 +: HIGH_CNT] = s_reg.pend[HIGH_BASE +: HIGH_CNT];
        ADDR_BRK_FLAG_CTRL: s_next.rdata[BREAK_CLEAR_FLAG_ENABLE_BIT] = s_reg.break_clear_flag_enable;
        ADDR_EVT_STAT: s_next.rdata[EVT_W-1:0] = s_reg.evt_stat;
        ADDR_EVT_MASK: s_next.rdata[EVT_W-1:0] = s_reg.evt_mask;
        default: ; // unmapped reads return zero
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.clr_allow <= 1'h1;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign rdata = s_reg.rdata;
  assign int_take = s_reg.take;
  assign reset_take = s_reg.take_reset;
  assign vector_addr = s_reg.vector;
  assign stack_pc_dec = s_reg.pc_dec;
  assign stack_index_high = s_reg.stack_h;
  assign set_int_mask = s_reg.set_imask;
  assign restore_regs = s_reg.restore;
  assign in_break = s_reg.in_brk;
  assign flag_clear_allow = s_reg.clr_allow;
  assign irq = s_reg.irq;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  a_take_boundary: assert property (@(posedge clk) disable iff (rst)
    s_reg.take |-> $past(instr_done))
    else $error("entry outside an instruction boundary");

  a_hw_mask_gate: assert property (@(posedge clk) disable iff (rst)
    (s_reg.take && s_reg.pc_dec) |-> (!$past(i_mask) && $past(s_reg.sel_valid)))
    else $error("hardware entry while masked or without a latched source");

  a_entry_masks: assert property (@(posedge clk) disable iff (rst)
    s_reg.take |-> s_reg.set_imask)
    else $error("entry without setting the interrupt mask");

  a_rti_restore: assert property (@(posedge clk) disable iff (rst)
    (rti_exec && !reset_req) |=> (restore_regs && !in_break))
    else $error("return did not restore registers");

  a_hw_vector: assert property (@(posedge clk) disable iff (rst)
    (s_reg.take && s_reg.pc_dec) |-> (s_reg.vector == VEC_FIRST - 16'({$past(s_reg.sel_idx), 1'h0})))
    else $error("hardware vector does not match latched source");

  a_latch_hold: assert property (@(posedge clk) disable iff (rst)
    ($past(s_reg.sel_valid) && s_reg.sel_valid) |-> $stable(s_reg.sel_idx))
    else $error("latched request displaced");

  a_priority_win: assert property (@(posedge clk) disable iff (rst)
    (!$past(s_reg.sel_valid) && s_reg.sel_valid) |->
      (($past(s_reg.pend & irq_enable) & (NSRC'(21'h1 << s_reg.sel_idx) - 21'h1)) == '0))
    else $error("a higher priority request was passed over");

  a_h_unstacked: assert property (@(posedge clk) disable iff (rst)
    int_take |-> !stack_index_high)
    else $error("index-high stacked on entry");

  a_swi_vector: assert property (@(posedge clk) disable iff (rst)
    (instr_done && swi_exec && !break_req && !reset_req) |=> (int_take && vector_addr == VEC_SWI && !stack_pc_dec))
    else $error("software interrupt not taken through its vector");

  a_reset_vector: assert property (@(posedge clk) disable iff (rst)
    reset_req |=> (reset_take && !int_take && vector_addr == VEC_RESET))
    else $error("reset not given its vector");

  a_break_entry: assert property (@(posedge clk) disable iff (rst)
    (instr_done && break_req && !reset_req) |=> (int_take && vector_addr == VEC_SWI && in_break))
    else $error("break did not force the software vector");

  a_break_guard: assert property (@(posedge clk) disable iff (rst)
    (in_break && !s_reg.break_clear_flag_enable) |-> !flag_clear_allow)
    else $error("flags clearable in break without enable");

  a_pend_readonly: assert property (@(posedge clk) disable iff (rst)
    (re && addr == ADDR_PEND_MID) |=> (rdata == $past(s_reg.pend[MID_BASE +: MID_CNT])))
    else $error("pending register read wrong");

  // no entry can start unless an instruction just ended
  a_nothing_mid: assert property (@(posedge clk) disable iff (rst)
    !instr_done |=> !int_take)
    else $error("entry without an instruction boundary");

  // a masked boundary with no software or break request fetches on
  a_masked_idle: assert property (@(posedge clk) disable iff (rst)
    (instr_done && i_mask && !swi_exec && !break_req) |=> !int_take)
    else $error("entry taken while masked");

  // disabled sources never reach the latch
  a_disabled_ignored: assert property (@(posedge clk) disable iff (rst)
    (!s_reg.sel_valid && !(|(s_reg.pend & irq_enable)) && !reset_req) |=> !s_reg.sel_valid)
    else $error("latch filled without an enabled request");

  // the mask is only set as part of an entry
  a_entry_mask_pulse: assert property (@(posedge clk) disable iff (rst)
    set_int_mask |-> int_take)
    else $error("mask set outside an entry");

  // restore is only ever the answer to a return
  a_restore_only_rti: assert property (@(posedge clk) disable iff (rst)
    restore_regs |-> ($past(rti_exec) && !$past(reset_req)))
    else $error("restore without a return");

  // a latched index always names a real source
  a_sel_idx_range: assert property (@(posedge clk) disable iff (rst)
    s_reg.sel_valid |-> (s_reg.sel_idx < IDX_W'(NSRC)))
    else $error("latched index out of range");

  // a falling mask empties the latch so arbitration can rerun
  a_latch_release: assert property (@(posedge clk) disable iff (rst)
    (s_reg.sel_valid && s_reg.imask_q && !i_mask && !reset_req) |=> !s_reg.sel_valid)
    else $error("latch kept after the mask cleared");

  // the winner must itself have been an enabled request
  a_latch_source: assert property (@(posedge clk) disable iff (rst)
    (!$past(s_reg.sel_valid) && s_reg.sel_valid) |->
      ((($past(s_reg.pend & irq_enable) >> s_reg.sel_idx) & NSRC'(1)) != '0))
    else $error("latched source was not requesting");

  // a request still latched at an open boundary is taken there
  a_return_pending: assert property (@(posedge clk) disable iff (rst)
    (instr_done && !i_mask && s_reg.sel_valid && !swi_exec && !break_req && !reset_req) |=>
      (int_take && stack_pc_dec))
    else $error("pending request skipped at boundary");

  // software interrupt goes through even with the mask set
  a_swi_unmasked: assert property (@(posedge clk) disable iff (rst)
    (instr_done && swi_exec && i_mask && !break_req && !reset_req) |=> (int_take && !stack_pc_dec))
    else $error("software interrupt blocked by the mask");

  // any entry not on the software vector is hardware and stacks PC minus one
  a_hw_pc_dec: assert property (@(posedge clk) disable iff (rst)
    (int_take && vector_addr != VEC_SWI) |-> stack_pc_dec)
    else $error("hardware entry stacked plain PC");

  // low pending register: flags in the upper six bits, the rest zero
  a_low_read: assert property (@(posedge clk) disable iff (rst)
    (re && addr == ADDR_PEND_LOW) |=>
      ((rdata[LOW_LSB-1:0] == '0) && (rdata[7:LOW_LSB] == $past(s_reg.pend[0 +: LOW_CNT]))))
    else $error("low pending register read wrong");

  // high pending register: top bit reads zero
  a_high_read: assert property (@(posedge clk) disable iff (rst)
    (re && addr == ADDR_PEND_HIGH) |=> (rdata == {1'h0, $past(s_reg.pend[HIGH_BASE +: HIGH_CNT])}))
    else $error("high pending register read wrong");

  // reset drops any latched request and leaves break
  a_reset_clears: assert property (@(posedge clk) disable iff (rst)
    reset_req |=> (!s_reg.sel_valid && !in_break && !restore_regs))
    else $error("reset left state behind");

  // break entry stacks plain PC and masks like a software interrupt
  a_break_pc: assert property (@(posedge clk) disable iff (rst)
    (instr_done && break_req && !reset_req) |=> (!stack_pc_dec && set_int_mask))
    else $error("break entry stacking wrong");

  // the mode field and the break output never disagree
  a_mode_agree: assert property (@(posedge clk) disable iff (rst)
    ((s_reg.mode == M_BREAK) == in_break))
    else $error("break mode and output disagree");

  // with the enable set, break no longer protects flags
  a_clr_enabled: assert property (@(posedge clk) disable iff (rst)
    (in_break && s_reg.break_clear_flag_enable) |-> flag_clear_allow)
    else $error("flags protected although enable set");

  // outside break the gate is always open, so cleared flags stay cleared
  a_clr_outside: assert property (@(posedge clk) disable iff (rst)
    !in_break |-> flag_clear_allow)
    else $error("flags protected outside break");

  // the gate is a pure level, moving only with break or the enable
  a_clr_level: assert property (@(posedge clk) disable iff (rst)
    $changed(flag_clear_allow) |-> ($changed(in_break) || $changed(s_reg.break_clear_flag_enable)))
    else $error("clear gate moved on its own");

  // the enable bit takes what software writes
  a_break_clear_flag_enable_write: assert property (@(posedge clk) disable iff (rst)
    (we && addr == ADDR_BRK_FLAG_CTRL) |=> (s_reg.break_clear_flag_enable == $past(wdata[BREAK_CLEAR_FLAG_ENABLE_BIT])))
    else $error("clear-flag enable write lost");

  // read data is zero outside the cycle after a read
  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !re |=> (rdata == '0))
    else $error("read data outside its cycle");

endmodule : exarb_exception_arbiter

//--- bench/exarb_src_model.sv
`timescale 1ns/1ps
// stand-in for the peripheral request sources
module exarb_src_model
  import exarb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NSRC-1:0] set_req,
  input wire logic [NSRC-1:0] clr_req,
  input wire logic int_take,
  input wire logic [15:0] vector_addr,
  output logic [NSRC-1:0] irq_src
);
  logic [NSRC-1:0] served;
  // a source drops its request once its own vector is taken, like a handler acknowledging it
  always_comb begin
    served = '0;
    if (int_take && vector_addr <= VEC_FIRST && vector_addr >= VEC_FIRST - 16'(2 * (NSRC - 1))) begin
      served[5'((VEC_FIRST - vector_addr) >> 1)] = 1'b1;
    end
  end
  // requests are levels that stay up until served or withdrawn
  always_ff @(posedge clk) begin
    if (rst) irq_src <= '0;
    else irq_src <= (irq_src & ~clr_req & ~served) | set_req;
  end
endmodule : exarb_src_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  import exarb_pkg::*;
  logic clk, rst, i_mask, instr_done, swi_exec, rti_exec, break_req, reset_req, we, re, re_q;
  logic [NSRC-1:0] irq_enable, set_req, clr_req, irq_src, r;
  logic [15:0] addr, vector_addr;
  logic [7:0] wdata, rdata;
  logic int_take, reset_take, stack_pc_dec, stack_index_high, set_int_mask, restore_regs;
  logic in_break, flag_clear_allow, irq;
  logic [7:0] rq[$];
  logic [18:0] tq[$];
  int err_count, checked, cyc;

  exarb_exception_arbiter u_dut (.clk(clk), .rst(rst), .irq_src(irq_src), .irq_enable(irq_enable),
    .i_mask(i_mask), .instr_done(instr_done), .swi_exec(swi_exec), .rti_exec(rti_exec),
    .break_req(break_req), .reset_req(reset_req), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .int_take(int_take), .reset_take(reset_take), .vector_addr(vector_addr),
    .stack_pc_dec(stack_pc_dec), .stack_index_high(stack_index_high), .set_int_mask(set_int_mask),
    .restore_regs(restore_regs), .in_break(in_break), .flag_clear_allow(flag_clear_allow), .irq(irq));
  exarb_src_model u_src (.clk(clk), .rst(rst), .set_req(set_req), .clr_req(clr_req),
    .int_take(int_take), .vector_addr(vector_addr), .irq_src(irq_src));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [18:0] e, logic [18:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    if (rq.size() != 0 || tq.size() != 0) err_count++;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    re <= 1'b0;
  endtask : rd
  task automatic src(logic [NSRC-1:0] s, logic [NSRC-1:0] c);
    @(posedge clk);
    set_req <= s;
    clr_req <= c;
    @(posedge clk);
    set_req <= '0;
    clr_req <= '0;
    step(3);
  endtask : src
  // one instruction boundary; t says whether an entry is due
  task automatic bnd(logic s, logic b, logic t, logic [18:0] e);
    @(posedge clk);
    instr_done <= 1'b1;
    swi_exec <= s;
    break_req <= b;
    if (t) tq.push_back(e);
    @(posedge clk);
    instr_done <= 1'b0;
    swi_exec <= 1'b0;
    break_req <= 1'b0;
    step(3);
  endtask : bnd
  // handler masks, then the mask falls and releases any stale latch
  task automatic isr();
    @(posedge clk);
    i_mask <= 1'b1;
    step(3);
    i_mask <= 1'b0;
    step(4);
  endtask : isr
  function automatic logic [18:0] hw(int i);
    return {3'b101, VEC_FIRST - 16'(2 * i)};
  endfunction : hw

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // results are matched against the oldest note when they appear
  always @(posedge clk) re_q <= re;
  always @(negedge clk) begin
    if (re_q) chk("rdata", 19'(rq.pop_front()), 19'(rdata));
    if (int_take) chk("entry", tq.pop_front(), {set_int_mask, stack_index_high, stack_pc_dec, vector_addr});
    if (reset_take) chk("reset vector", tq.pop_front(), 19'(vector_addr));
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    {i_mask, instr_done, swi_exec, rti_exec, break_req, reset_req, we, re} = '0;
    {addr, wdata, irq_enable, set_req, clr_req} = '0;
    rst = 1'b1;
    err_count = 0;
    checked = 0;
    cyc = 0;
    r = NSRC'($urandom(32'haa9a));
    step(4);
    rst <= 1'b0;
    @(negedge clk);
    chk("idle", 19'h1, 19'({int_take, reset_take, in_break, irq, restore_regs, flag_clear_allow}));
    // pending registers mirror raw requests, never written
    r = NSRC'($urandom);
    src(r, '0);
    rd(ADDR_PEND_LOW, {r[5:0], 2'b00});
    rd(ADDR_PEND_MID, r[13:6]);
    wr(ADDR_PEND_MID, ~r[13:6]);
    rd(ADDR_PEND_MID, r[13:6]);
    rd(ADDR_PEND_HIGH, {1'b0, r[20:14]});
    rd(16'hfe0f, 8'h00);
    src('0, '1);
    wr(ADDR_EVT_MASK, 8'h01);
    irq_enable <= '1;
    src(21'h9, '0);
    i_mask <= 1'b1;
    bnd(1'b0, 1'b0, 1'b0, '0);
    isr();
    bnd(1'b0, 1'b0, 1'b1, hw(0));
    @(negedge clk);
    chk("irq", 19'h1, 19'(irq));
    isr();
    bnd(1'b0, 1'b0, 1'b1, hw(3));
    wr(ADDR_EVT_STAT, 8'h01);
    @(negedge clk);
    chk("irq", 19'h0, 19'(irq));
    isr();
    src(21'h100000, '0);
    src(21'h1, '0);
    bnd(1'b0, 1'b0, 1'b1, hw(20));
    isr();
    bnd(1'b0, 1'b0, 1'b1, hw(0));
    isr();
    bnd(1'b0, 1'b0, 1'b0, '0);
    i_mask <= 1'b1;
    bnd(1'b1, 1'b0, 1'b1, {3'b100, VEC_SWI});
    bnd(1'b0, 1'b1, 1'b1, {3'b100, VEC_SWI});
    @(negedge clk);
    chk("break state", 19'h2, 19'({in_break, flag_clear_allow}));
    rd(ADDR_BRK_FLAG_CTRL, 8'h00);
    wr(ADDR_BRK_FLAG_CTRL, 8'h80);
    @(negedge clk);
    chk("clear allow", 19'h1, 19'(flag_clear_allow));
    rd(ADDR_BRK_FLAG_CTRL, 8'h80);
    rti_exec <= 1'b1;
    @(posedge clk);
    rti_exec <= 1'b0;
    @(negedge clk);
    chk("restore", 19'h1, 19'(restore_regs));
    @(negedge clk);
    chk("break exit", 19'h1, 19'({in_break, flag_clear_allow}));
    @(posedge clk);
    i_mask <= 1'b0;
    src(21'h20, '0);
    reset_req <= 1'b1;
    tq.push_back({3'h0, VEC_RESET});
    @(posedge clk);
    reset_req <= 1'b0;
    step(3);
    bnd(1'b0, 1'b0, 1'b1, hw(5));
    step(5);
    end_of_test();
  end
endmodule : tb
